// File: core/sfe_force_regs.sv
`timescale 1ns/1ps
`default_nettype none
module sfe_force_regs
   import sfe_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [ADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [3:0] card_cap_in,
   input wire logic card_cb_in,
   input wire logic card_16b_in,
   input wire logic interrogate_done_in,
   input wire logic [3:0] event_hw_in,
   input wire logic [3:0] status_live_in,
   output logic interrogate_out,
   output logic control_enabled_out,
   output logic [2:0] supply_ctrl_out,
   output logic [2:0] prog_ctrl_out,
   output logic clk_stop_ok_out
);
   logic access;
   logic wr;
   logic rd;
   logic [31:0] wmask;
   logic [31:0] event_word;
   logic [31:0] present_word;
   logic [31:0] ev_load;
   logic [31:0] pr_load;
   logic [31:0] pr_val;
   logic [31:0] status_word;
   logic [31:0] control_word;
   logic [3:0] socket_cap;
   logic pending;
   logic next_control_enabled;

   function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      is_reg = (a == ADDR_W'(ofs));
   endfunction

   assign access = psel_in & penable_in;
   assign wr = access & pwrite_in;
   assign rd = access & ~pwrite_in;
   assign wmask = pwdata_in & SFE_FORCE_WMASK;

   // Force write steers events and present-state; nothing kept here
   always_comb begin
      ev_load = '0;
      pr_load = '0;
      pr_val = '0;
      if (wr && is_reg(paddr_in, SFE_FORCE_OFS)) begin
         ev_load = SFE_EVENT_MASK;
         pr_load = SFE_PRESENT_FORCE_MASK;
         pr_val = wmask;
      end else if (interrogate_done_in && pending) begin
         pr_load = SFE_INTERROGATE_MASK;
         pr_val = {18'h00000, card_cap_in, 4'h0, card_cb_in, card_16b_in, 4'h0};
      end
   end

   // Events: write-one-to-clear, hardware set wins
   sfe_word_reg #(.RESET_VALUE(SFE_RESET_WORD)) u_event (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .ce_in(ce_in),
      .mask_in(SFE_EVENT_MASK),
      .set_in({28'h0000000, event_hw_in}),
      .clr_in((wr && is_reg(paddr_in, SFE_EVENT_OFS)) ? pwdata_in : 32'h00000000),
      .load_en_in(ev_load),
      .load_val_in(wmask),
      .q_out(event_word)
   );

   sfe_word_reg #(.RESET_VALUE(SFE_RESET_WORD)) u_present (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .ce_in(ce_in),
      .mask_in(SFE_PRESENT_FORCE_MASK),
      .set_in(32'h00000000),
      .clr_in(32'h00000000),
      .load_en_in(pr_load),
      .load_val_in(pr_val),
      .q_out(present_word)
   );

   // Socket capability defaults, overridable by force voltage bits
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         socket_cap <= SFE_SOCK_CAP_RESET;
      end else if (ce_in && wr && is_reg(paddr_in, SFE_FORCE_OFS)) begin
         socket_cap <= wmask[SFE_YV_BIT:SFE_5V_BIT];
      end
   end

   always_comb begin
      next_control_enabled = control_enabled_out;
      if (wr && is_reg(paddr_in, SFE_FORCE_OFS)) begin
         if (|wmask[SFE_YV_BIT:SFE_5V_BIT]) begin
            next_control_enabled = 1'b0;
         end
         if (wmask[SFE_RETEST_BIT]) begin
            next_control_enabled = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         control_enabled_out <= 1'b1;
         interrogate_out <= 1'b0;
         pending <= 1'b0;
      end else if (ce_in) begin
         control_enabled_out <= next_control_enabled;
         interrogate_out <= 1'b0;
         if (wr && is_reg(paddr_in, SFE_FORCE_OFS) && wmask[SFE_RETEST_BIT]) begin
            interrogate_out <= 1'b1;
            pending <= 1'b1;
         end else if (interrogate_done_in) begin
            pending <= 1'b0;
         end
      end
   end

   // Socket control writes only take while enabled
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         control_word <= SFE_RESET_WORD;
      end else if (ce_in && wr && is_reg(paddr_in, SFE_CONTROL_OFS) && control_enabled_out) begin
         control_word <= pwdata_in & SFE_CONTROL_MASK;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         supply_ctrl_out <= 3'h0;
         prog_ctrl_out <= 3'h0;
         clk_stop_ok_out <= 1'b0;
      end else if (ce_in) begin
         supply_ctrl_out <= control_enabled_out ? control_word[6:4] : 3'h0;
         prog_ctrl_out <= control_enabled_out ? control_word[2:0] : 3'h0;
         clk_stop_ok_out <= control_word[7];
      end
   end

   always_comb begin
      status_word = present_word;
      status_word[SFE_SOCK_YV_BIT:SFE_SOCK_5V_BIT] = socket_cap;
      status_word[SFE_PWR_BIT:SFE_STS_BIT] = status_live_in;
   end

   // APB slave: zero wait state, unmapped reads zero with error
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         prdata_out <= 32'h00000000;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end else if (ce_in) begin
         pready_out <= psel_in & ~penable_in;
         pslverr_out <= psel_in & ~penable_in & ~(is_reg(paddr_in, SFE_EVENT_OFS)
            | is_reg(paddr_in, SFE_PRESENT_OFS) | is_reg(paddr_in, SFE_FORCE_OFS)
            | is_reg(paddr_in, SFE_CONTROL_OFS));
         prdata_out <= 32'h00000000;
         if (psel_in && !penable_in && !pwrite_in) begin
            if (is_reg(paddr_in, SFE_EVENT_OFS)) prdata_out <= event_word;
            else if (is_reg(paddr_in, SFE_PRESENT_OFS)) prdata_out <= status_word;
            else if (is_reg(paddr_in, SFE_CONTROL_OFS)) prdata_out <= control_word;
            else prdata_out <= 32'h00000000;
         end
      end
   end
endmodule
`default_nettype wire

// File: core/sfe_pkg.sv
// Contract
// - Force register at 0Ch; event 00h, present 08h
// - Bits 31..15 read zero, writes ignored
// - Bit 6 reads zero
// - Retest re-interrogates card, re-enables socket control
// - Bit 13 loads present-state Y.Y capable flag
// - Bit 12 loads present-state X.X capable flag
// - Bit 11 loads present-state 3.3 V flag
// - Bit 10 loads present-state 5 V flag
// - Any voltage force one disables socket control unless retest is also set
// - Bit 9 loads bad supply request flag
// - Bit 8 loads possible data loss flag
// - Bit 7 loads unrecognized card flag
// - Bit 5 loads CardBus detected flag
// - Bit 4 loads sixteen-bit detected flag
// - Bit 3 loads power event; powered status kept
// - Bit 2 loads detect-two event; status kept
// - Bit 1 loads detect-one event; status kept
// - Bit 0 loads status-change event; level kept
// - Socket 3.3 V, 5 V capability default set
// - Socket Y.Y, X.X capability default cleared
`default_nettype none
package sfe_pkg;
   localparam logic [7:0] SFE_EVENT_OFS = 8'h00;
   localparam logic [7:0] SFE_PRESENT_OFS = 8'h08;
   localparam logic [7:0] SFE_FORCE_OFS = 8'h0C;
   localparam logic [7:0] SFE_CONTROL_OFS = 8'h10;
   localparam int SFE_RETEST_BIT = 14;
   localparam int SFE_YV_BIT = 13;
   localparam int SFE_XV_BIT = 12;
   localparam int SFE_3V_BIT = 11;
   localparam int SFE_5V_BIT = 10;
   localparam int SFE_BADREQ_BIT = 9;
   localparam int SFE_DLOSS_BIT = 8;
   localparam int SFE_NOTCARD_BIT = 7;
   localparam int SFE_CB_BIT = 5;
   localparam int SFE_16B_BIT = 4;
   localparam int SFE_PWR_BIT = 3;
   localparam int SFE_CD2_BIT = 2;
   localparam int SFE_CD1_BIT = 1;
   localparam int SFE_STS_BIT = 0;
   localparam int SFE_SOCK_YV_BIT = 31;
   localparam int SFE_SOCK_XV_BIT = 30;
   localparam int SFE_SOCK_3V_BIT = 29;
   localparam int SFE_SOCK_5V_BIT = 28;
   localparam logic [31:0] SFE_FORCE_WMASK = 32'h00007FBF;
   localparam logic [31:0] SFE_PRESENT_FORCE_MASK = 32'h00003FB0;
   localparam logic [31:0] SFE_EVENT_MASK = 32'h0000000F;
   localparam logic [31:0] SFE_CONTROL_MASK = 32'h000000F7;
   localparam logic [31:0] SFE_INTERROGATE_MASK = 32'h00003C30;
   localparam logic [3:0] SFE_SOCK_CAP_RESET = 4'h3;
   localparam logic [31:0] SFE_RESET_WORD = 32'h00000000;
endpackage
`default_nettype wire

// File: core/sfe_word_reg.sv
`timescale 1ns/1ps
`default_nettype none
module sfe_word_reg
   import sfe_pkg::*;
#(
   parameter logic [31:0] RESET_VALUE = 32'h00000000
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   input wire logic [31:0] mask_in,
   input wire logic [31:0] set_in,
   input wire logic [31:0] clr_in,
   input wire logic [31:0] load_en_in,
   input wire logic [31:0] load_val_in,
   output logic [31:0] q_out
);
   // Hardware set wins over load and clear; load beats clear
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         q_out <= RESET_VALUE;
      end else if (ce_in) begin
         q_out <= (set_in | (load_en_in & load_val_in) | (~load_en_in & q_out & ~clr_in))
                  & mask_in;
      end
   end
endmodule
`default_nettype wire

// File: testbench/sfe_force_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sfe_force_regs_sva #(
   parameter int ADDR_W = 8
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [ADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic interrogate_out,
   input wire logic control_enabled_out,
   input wire logic [2:0] supply_ctrl_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   logic acc;
   logic fw;
   assign acc = ce_in && psel_in && penable_in && pready_out && paddr_in == ADDR_W'(8'h0C);
   assign fw = acc && pwrite_in;
   property p_answer; ce_in && psel_in && !penable_in |=> pready_out; endproperty
   a_answer: assert property (p_answer) else $error("no answer after setup");
   property p_read_zero; acc && !pwrite_in |-> prdata_out == 32'h00000000; endproperty
   a_read_zero: assert property (p_read_zero) else $error("force read not zero");
   property p_retest; fw && pwdata_in[14] |=> interrogate_out && control_enabled_out; endproperty
   a_retest: assert property (p_retest) else $error("retest not acted on");
   property p_pulse; interrogate_out |-> $past(fw && pwdata_in[14]); endproperty
   a_pulse: assert property (p_pulse) else $error("stray interrogation");
   property p_disable; fw && !pwdata_in[14] && |pwdata_in[13:10] |=> !control_enabled_out;
   endproperty
   a_disable: assert property (p_disable) else $error("control not disabled");
   property p_hold; fw && pwdata_in[14:10] == 5'h00 |=> $stable(control_enabled_out); endproperty
   a_hold: assert property (p_hold) else $error("enable moved");
   property p_gate; !control_enabled_out [*2] |-> supply_ctrl_out == 3'h0; endproperty
   a_gate: assert property (p_gate) else $error("supply live while disabled");
   property p_rise; $past(rstn_in) && $rose(control_enabled_out) |-> $past(fw && pwdata_in[14]);
   endproperty
   a_rise: assert property (p_rise) else $error("enable without retest");
   c_retest: cover property (fw && pwdata_in[14]);
   c_disable: cover property (fw && !pwdata_in[14] && |pwdata_in[13:10]);
   c_read: cover property (acc && !pwrite_in);
endmodule
bind sfe_force_regs sfe_force_regs_sva #(.ADDR_W(ADDR_W)) u_sfe_force_regs_sva (
   .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
   .prdata_out(prdata_out), .pready_out(pready_out), .interrogate_out(interrogate_out),
   .control_enabled_out(control_enabled_out), .supply_ctrl_out(supply_ctrl_out));
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sfe_pkg::*;
   typedef struct {logic [31:0] w; logic [31:0] pres; logic [3:0] ev; logic en;} sfe_row_t;
   logic clk_in = 0, rstn_in = 0, psel = 0, pen = 0, pwr = 0, done = 0, cb = 0, ce = 1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata, q;
   logic pready, pslverr, itg, en, e, stop;
   logic [2:0] sup, prog;
   logic [3:0] cap = 4'h0, hw = 4'h0, live = 4'hA;
   int errors = 0, n_checks = 0, cyc = 0;
   sfe_row_t rows [4] = '{'{32'h00002AA5, 32'hA0002AAA, 4'h5, 1'b0},
      '{32'h00005555, 32'h5000151A, 4'h5, 1'b1}, '{32'hFFFF8000, 32'h0000000A, 4'h0, 1'b1},
      '{32'h00003FBF, 32'hF0003FBA, 4'hF, 1'b0}};
   sfe_force_regs u_sfe_force_regs (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce),
      .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .card_cap_in(cap),
      .card_cb_in(cb), .card_16b_in(1'b0), .interrogate_done_in(done), .event_hw_in(hw),
      .status_live_in(live), .interrogate_out(itg), .control_enabled_out(en),
      .supply_ctrl_out(sup), .prog_ctrl_out(prog), .clk_stop_ok_out(stop));
   always #5 clk_in = ~clk_in;
   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk_in) begin
      cyc++;
      if (cyc > 2000) begin
         errors++;
         wrap_up();
      end
   end
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
      n_checks++;
      if (x !== y) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, x, y);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel <= 1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      pen <= 1;
      do begin
         @(posedge clk_in);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 0;
      pen <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
      xfer(1'b0, a, 32'h00000000);
      chk({nm, " err"}, {31'h0, a == 8'h04}, {31'h0, e});
      if (a != 8'h04)
         chk(nm, x, q);
   endtask
   initial begin
      repeat (20) @(posedge clk_in);
      rstn_in <= 1;
      rd(8'h08, 32'h3000000A, "present");
      rd(8'h00, 32'h00000000, "event");
      rd(8'h04, 32'h00000000, "unmapped");
      xfer(1'b1, 8'h10, 32'h000000B7);
      rd(8'h10, 32'h000000B7, "control");
      chk("supply", 32'h3, {29'h0, sup});
      chk("prog", 32'h7, {29'h0, prog});
      chk("stop", 32'h1, {31'h0, stop});
      foreach (rows[i]) begin
         xfer(1'b1, 8'h0C, rows[i].w);
         rd(8'h0C, 32'h00000000, "force");
         rd(8'h08, rows[i].pres, "present");
         rd(8'h00, {28'h0, rows[i].ev}, "event");
         chk("enable", {31'h0, rows[i].en}, {31'h0, en});
      end
      xfer(1'b1, 8'h10, 32'h00000025);
      rd(8'h10, 32'h000000B7, "refused control");
      chk("supply", 32'h0, {29'h0, sup});
      chk("prog", 32'h0, {29'h0, prog});
      chk("stop", 32'h1, {31'h0, stop});
      xfer(1'b1, 8'h0C, 32'h00004000);
      @(posedge clk_in);
      chk("interrogate", 32'h1, {31'h0, itg});
      cap <= 4'h6;
      cb <= 1;
      done <= 1;
      @(posedge clk_in);
      done <= 0;
      rd(8'h08, 32'h0000182A, "present");
      chk("enable", 32'h1, {31'h0, en});
      chk("supply", 32'h3, {29'h0, sup});
      live <= 4'h5;
      xfer(1'b1, 8'h0C, 32'h0000040F);
      rd(8'h08, 32'h10000405, "present live");
      chk("enable", 32'h0, {31'h0, en});
      xfer(1'b1, 8'h00, 32'h00000003);
      rd(8'h00, 32'h0000000C, "event clear");
      hw <= 4'h1;
      @(posedge clk_in);
      hw <= 4'h0;
      rd(8'h00, 32'h0000000D, "event set");
      ce <= 1'b0;
      hw <= 4'h2;
      @(posedge clk_in);
      hw <= 4'h0;
      @(posedge clk_in);
      ce <= 1'b1;
      rd(8'h00, 32'h0000000D, "event frozen");
      rstn_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rstn_in <= 1'b1;
      rd(8'h08, 32'h30000005, "reset present");
      rd(8'h00, 32'h00000000, "reset event");
      rd(8'h10, 32'h00000000, "reset control");
      chk("reset enable", 32'h1, {31'h0, en});
      wrap_up();
   end
endmodule
`default_nettype wire
